// [logic/insn_exec_pkg.sv]
// shared constants and carriers for the logical/trap/atomic execution unit
// assumes a 16-bit instruction word, 32-bit registers and a byte-wide memory port
package insn_exec_pkg;
	// opcode patterns, masks select the fixed bits
	localparam logic [15:0] OPC_SWAPB = 16'h6008;
	localparam logic [15:0] OPC_SWAPW = 16'h6009;
	localparam logic [15:0] OPC_TAS = 16'h401B;
	localparam logic [15:0] OPC_TRAP = 16'hC300;
	localparam logic [15:0] OPC_TSTR = 16'h2008;
	localparam logic [15:0] OPC_TSTI = 16'hC800;
	localparam logic [15:0] OPC_TSTM = 16'hCC00;
	localparam logic [15:0] OPC_XORR = 16'h200A;
	localparam logic [15:0] OPC_XORI = 16'hCA00;
	localparam logic [15:0] OPC_XORM = 16'hCE00;
	localparam logic [15:0] MASK_RR = 16'hF00F;
	localparam logic [15:0] MASK_RN = 16'hF0FF;
	localparam logic [15:0] MASK_IMM = 16'hFF00;
	// status word bit positions
	localparam int SR_T_POS = 0;
	localparam int SR_BANK_POS = 29;
	localparam int SR_BL_POS = 28;
	localparam int SR_MD_POS = 30;
	// trap, pc step and test-and-set constants
	localparam logic [31:0] TRAP_EVT_CODE = 32'h0000_0160;
	localparam logic [31:0] TRAP_VEC_OFS = 32'h0000_0100;
	localparam logic [31:0] PC_STEP = 32'h0000_0002;
	localparam logic [7:0] TAS_SET_BIT = 8'h80;
	// reset values
	localparam logic [31:0] SR_RESET = 32'h0000_0000; // arbitrary start: mode, mask and bank bits clear
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
	// memory request carrier
	typedef struct packed {
		logic req;
		logic wr;
		logic lock;
		logic purge;
		logic [31:0] addr;
		logic [7:0] wdata;
	} mem_req_t;
	// register write-back carrier
	typedef struct packed {
		logic we;
		logic [3:0] idx;
		logic [31:0] data;
	} reg_wb_t;
endpackage : insn_exec_pkg

// [logic/insn_exec.sv]
// execution unit for swap, test-and-set, trap, and-test and exclusive-or
// assumes the core hands one instruction with operands and waits for done_out;
// memory answers a request with mem_ack_in, read data valid in that cycle
`default_nettype none
module insn_exec (
	input wire logic clk_in, // core clock
	input wire logic srst_in, // synchronous reset, active high
	input wire logic start_in, // one-cycle issue strobe
	input wire logic [15:0] opcode_in, // instruction word
	input wire logic [31:0] pc_in, // address of the instruction
	input wire logic [31:0] rm_in, // source register value
	input wire logic [31:0] rn_in, // destination register value
	input wire logic [31:0] r0_in, // register zero value
	input wire logic [31:0] global_base_in, // global base register
	input wire logic [31:0] vector_base_in, // vector base register
	input wire logic mem_ack_in, // memory accepted or answered
	input wire logic [7:0] mem_rdata_in, // read byte
	input wire logic cache_hit_in, // purge address hits the cache
	input wire logic dirty_mark_in, // hit line is dirty
	input wire logic cacheable_in, // address is cacheable
	output logic busy_out, // instruction in progress
	output logic done_out, // one-cycle completion pulse
	output insn_exec_pkg::mem_req_t mem_out, // memory request
	output logic access_store_out, // protection check as byte store
	output logic line_wb_out, // write dirty line back
	output logic line_inval_out, // clear line_ok of the line
	output insn_exec_pkg::reg_wb_t wb_out, // register write-back
	output logic [31:0] next_pc_out, // fetch address after completion
	output logic [31:0] status_word_out, // status word
	output logic [31:0] saved_status_out, // saved status
	output logic [31:0] saved_pc_out, // saved pc
	output logic [31:0] software_exc_code_out, // trap code register
	output logic [31:0] exception_event_code_out // event code register
);
	// one-hot sequencer states
	typedef enum logic [6:0] {
		ST_IDLE = 7'b000_0001,
		ST_PURGE = 7'b000_0010,
		ST_WBACK = 7'b000_0100,
		ST_READ = 7'b000_1000,
		ST_WRITE = 7'b001_0000,
		ST_DONE = 7'b010_0000,
		ST_TRAP = 7'b100_0000
	} state_t;
	// operation kinds
	typedef enum logic [3:0] {
		OP_NONE, OP_SWAPB, OP_SWAPW, OP_TAS, OP_TRAP, OP_TSTR, OP_TSTI, OP_TSTM, OP_XORR, OP_XORI, OP_XORM
	} op_t;

	// decode, used at issue and by checks
	function automatic op_t decode(input logic [15:0] w);
		if ((w & insn_exec_pkg::MASK_RR) == insn_exec_pkg::OPC_SWAPB) return OP_SWAPB;
		if ((w & insn_exec_pkg::MASK_RR) == insn_exec_pkg::OPC_SWAPW) return OP_SWAPW;
		if ((w & insn_exec_pkg::MASK_RN) == insn_exec_pkg::OPC_TAS) return OP_TAS;
		if ((w & insn_exec_pkg::MASK_IMM) == insn_exec_pkg::OPC_TRAP) return OP_TRAP;
		if ((w & insn_exec_pkg::MASK_RR) == insn_exec_pkg::OPC_TSTR) return OP_TSTR;
		if ((w & insn_exec_pkg::MASK_IMM) == insn_exec_pkg::OPC_TSTI) return OP_TSTI;
		if ((w & insn_exec_pkg::MASK_IMM) == insn_exec_pkg::OPC_TSTM) return OP_TSTM;
		if ((w & insn_exec_pkg::MASK_RR) == insn_exec_pkg::OPC_XORR) return OP_XORR;
		if ((w & insn_exec_pkg::MASK_IMM) == insn_exec_pkg::OPC_XORI) return OP_XORI;
		if ((w & insn_exec_pkg::MASK_IMM) == insn_exec_pkg::OPC_XORM) return OP_XORM;
		return OP_NONE;
	endfunction

	state_t state_q, state_d; // sequencer
	op_t op_q, op_d; // latched operation
	logic [15:0] opc_q, opc_d; // latched opcode
	logic [31:0] pc_q, pc_d; // latched pc
	logic [31:0] addr_q, addr_d; // byte address
	logic [7:0] rbyte_q, rbyte_d; // byte read
	logic [31:0] sr_q, sr_d; // status word
	logic [31:0] ssr_q, ssr_d; // saved status
	logic [31:0] spc_q, spc_d; // saved pc
	logic [31:0] tra_q, tra_d; // trap code
	logic [31:0] evt_q, evt_d; // event code
	logic [31:0] npc_q, npc_d; // next fetch address
	logic done_q, done_d; // completion pulse
	insn_exec_pkg::reg_wb_t wb_q, wb_d; // write-back
	insn_exec_pkg::mem_req_t mem_q, mem_d; // memory request
	logic wbk_q, wbk_d; // line write-back strobe
	logic inv_q, inv_d; // line invalidate strobe
	logic [7:0] imm; // immediate byte of the latched opcode
	op_t op_new; // decode of the incoming word

	assign imm = opc_q[7:0];
	assign op_new = decode(opcode_in);

	// next state and datapath
	always_comb begin
		state_d = state_q;
		op_d = op_q;
		opc_d = opc_q;
		pc_d = pc_q;
		addr_d = addr_q;
		rbyte_d = rbyte_q;
		sr_d = sr_q;
		ssr_d = ssr_q;
		spc_d = spc_q;
		tra_d = tra_q;
		evt_d = evt_q;
		npc_d = npc_q;
		done_d = 1'b0;
		wb_d = '0;
		mem_d = mem_q;
		wbk_d = 1'b0;
		inv_d = 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (start_in) begin
					op_d = op_new;
					opc_d = opcode_in;
					pc_d = pc_in;
					npc_d = pc_in + insn_exec_pkg::PC_STEP;
					case (op_new)
						OP_SWAPB: begin
							wb_d = '{1'b1, opcode_in[11:8], {rm_in[31:16], rm_in[7:0], rm_in[15:8]}};
							done_d = 1'b1;
						end
						OP_SWAPW: begin
							wb_d = '{1'b1, opcode_in[11:8], {rm_in[15:0], rm_in[31:16]}};
							done_d = 1'b1;
						end
						OP_TSTR: begin
							sr_d[insn_exec_pkg::SR_T_POS] = ((rn_in & rm_in) == insn_exec_pkg::ZERO_WORD);
							done_d = 1'b1;
						end
						OP_TSTI: begin
							sr_d[insn_exec_pkg::SR_T_POS] = ((r0_in[7:0] & opcode_in[7:0]) == 8'h00);
							done_d = 1'b1;
						end
						OP_XORR: begin
							wb_d = '{1'b1, opcode_in[11:8], rn_in ^ rm_in};
							done_d = 1'b1;
						end
						OP_XORI: begin
							wb_d = '{1'b1, 4'h0, r0_in ^ {24'h00_0000, opcode_in[7:0]}};
							done_d = 1'b1;
						end
						OP_TAS: begin
							addr_d = rn_in;
							state_d = ST_PURGE;
						end
						OP_TSTM, OP_XORM: begin
							addr_d = global_base_in + r0_in;
							mem_d = '{1'b1, 1'b0, 1'b0, 1'b0, global_base_in + r0_in, 8'h00};
							state_d = ST_READ;
						end
						OP_TRAP: state_d = ST_TRAP;
						default: done_d = 1'b1;
					endcase
				end
			end
			ST_PURGE: begin
				// purge decision on the cache lookup
				if (cache_hit_in && cacheable_in && dirty_mark_in) begin
					wbk_d = 1'b1;
					mem_d = '{1'b1, 1'b1, 1'b1, 1'b1, addr_q, 8'h00};
					state_d = ST_WBACK;
				end else begin
					inv_d = cache_hit_in && cacheable_in;
					mem_d = '{1'b1, 1'b0, 1'b1, 1'b0, addr_q, 8'h00};
					state_d = ST_READ;
				end
			end
			ST_WBACK: begin
				// line copy-back finished, then invalidate and read
				if (mem_ack_in) begin
					inv_d = 1'b1;
					mem_d = '{1'b1, 1'b0, 1'b1, 1'b0, addr_q, 8'h00};
					state_d = ST_READ;
				end
			end
			ST_READ: begin
				if (mem_ack_in) begin
					rbyte_d = mem_rdata_in;
					case (op_q)
						OP_TAS: begin
							sr_d[insn_exec_pkg::SR_T_POS] = (mem_rdata_in == 8'h00);
							mem_d = '{1'b1, 1'b1, 1'b1, 1'b0, addr_q, mem_rdata_in | insn_exec_pkg::TAS_SET_BIT};
							state_d = ST_WRITE;
						end
						OP_XORM: begin
							mem_d = '{1'b1, 1'b1, 1'b0, 1'b0, addr_q, mem_rdata_in ^ imm};
							state_d = ST_WRITE;
						end
						default: begin
							sr_d[insn_exec_pkg::SR_T_POS] = ((mem_rdata_in & imm) == 8'h00);
							mem_d = '0;
							state_d = ST_DONE;
						end
					endcase
				end
			end
			ST_WRITE: begin
				if (mem_ack_in) begin
					mem_d = '0; // lock drops with the write
					state_d = ST_DONE;
				end
			end
			ST_TRAP: begin
				tra_d = {22'h00_0000, imm, 2'b00};
				spc_d = pc_q + insn_exec_pkg::PC_STEP;
				ssr_d = sr_q;
				sr_d[insn_exec_pkg::SR_MD_POS] = 1'b1;
				sr_d[insn_exec_pkg::SR_BL_POS] = 1'b1;
				sr_d[insn_exec_pkg::SR_BANK_POS] = 1'b1;
				evt_d = {evt_q[31:12], insn_exec_pkg::TRAP_EVT_CODE[11:0]};
				npc_d = vector_base_in + insn_exec_pkg::TRAP_VEC_OFS;
				state_d = ST_DONE;
			end
			ST_DONE: begin
				done_d = 1'b1;
				state_d = ST_IDLE;
			end
			default: state_d = ST_IDLE;
		endcase
	end

	// registers only
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			state_q <= ST_IDLE;
			op_q <= OP_NONE;
			opc_q <= 16'h0000;
			pc_q <= insn_exec_pkg::ZERO_WORD;
			addr_q <= insn_exec_pkg::ZERO_WORD;
			rbyte_q <= 8'h00;
			sr_q <= insn_exec_pkg::SR_RESET;
			ssr_q <= insn_exec_pkg::ZERO_WORD;
			spc_q <= insn_exec_pkg::ZERO_WORD;
			tra_q <= insn_exec_pkg::ZERO_WORD;
			evt_q <= insn_exec_pkg::ZERO_WORD;
			npc_q <= insn_exec_pkg::ZERO_WORD;
			done_q <= 1'b0;
			wb_q <= '0;
			mem_q <= '0;
			wbk_q <= 1'b0;
			inv_q <= 1'b0;
		end else begin
			state_q <= state_d;
			op_q <= op_d;
			opc_q <= opc_d;
			pc_q <= pc_d;
			addr_q <= addr_d;
			rbyte_q <= rbyte_d;
			sr_q <= sr_d;
			ssr_q <= ssr_d;
			spc_q <= spc_d;
			tra_q <= tra_d;
			evt_q <= evt_d;
			npc_q <= npc_d;
			done_q <= done_d;
			wb_q <= wb_d;
			mem_q <= mem_d;
			wbk_q <= wbk_d;
			inv_q <= inv_d;
		end
	end

	// outputs
	assign busy_out = (state_q != ST_IDLE);
	assign done_out = done_q;
	assign mem_out = mem_q;
	assign access_store_out = mem_q.req && (op_q == OP_TAS);
	assign line_wb_out = wbk_q;
	assign line_inval_out = inv_q;
	assign wb_out = wb_q;
	assign next_pc_out = npc_q;
	assign status_word_out = sr_q;
	assign saved_status_out = ssr_q;
	assign saved_pc_out = spc_q;
	assign software_exc_code_out = tra_q;
	assign exception_event_code_out = evt_q;

	// lock held while the test-and-set write is pending in ST_WRITE
	tas_lock_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(state_q == ST_WRITE && op_q == OP_TAS) |-> mem_q.lock)
		else $error("lock dropped between read and write");
	// written byte is the read byte with bit 7 set
	tas_bit7_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(state_q == ST_WRITE && op_q == OP_TAS) |-> mem_q.wr && mem_q.wdata == (rbyte_q | insn_exec_pkg::TAS_SET_BIT))
		else $error("test-and-set write lacks bit 7");
	// flag from the read byte
	tas_flag_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(state_q == ST_READ && op_q == OP_TAS && mem_ack_in) |=> sr_q[0] == ($past(mem_rdata_in) == 8'h00))
		else $error("test-and-set flag wrong");
	// dirty hit copies back before invalidate
	dirty_purge_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(state_q == ST_PURGE && cache_hit_in && cacheable_in && dirty_mark_in) |=> line_wb_out && !line_inval_out)
		else $error("dirty line not written back");
	// clean hit is only invalidated, never copied back
	clean_purge_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(state_q == ST_PURGE && cache_hit_in && cacheable_in && !dirty_mark_in) |=> line_inval_out && !line_wb_out)
		else $error("clean line not invalidated");
	// miss never invalidates
	miss_skip_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(state_q == ST_PURGE && !(cache_hit_in && cacheable_in)) |=> !line_inval_out && !line_wb_out)
		else $error("purge on a miss");
	// memory xor writes the read byte xor the immediate
	xor_write_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(state_q == ST_WRITE && op_q == OP_XORM) |-> mem_q.wr && mem_q.wdata == (rbyte_q ^ imm))
		else $error("memory xor write wrong");
	// trap vector and event code
	trap_vec_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(state_q == ST_TRAP) |=> next_pc_out == $past(vector_base_in) + 32'h0000_0100
		&& exception_event_code_out[11:0] == 12'h160)
		else $error("trap vector or event code wrong");
	// trap saves the address after the instruction
	trap_pc_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(state_q == ST_TRAP) |=> saved_pc_out == $past(pc_q) + insn_exec_pkg::PC_STEP)
		else $error("trap saved pc wrong");
	// trap status bits
	trap_sr_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(state_q == ST_TRAP) |=> sr_q[30] && sr_q[29] && sr_q[28] && saved_status_out == $past(sr_q))
		else $error("trap status not set");
	// trap code is shifted immediate
	trap_code_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(state_q == ST_TRAP) |=> software_exc_code_out == {22'h00_0000, $past(imm), 2'b00})
		else $error("trap code wrong");
	// register and-test finishes next cycle with pc plus two and no write-back
	one_state_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(state_q == ST_IDLE && start_in && decode(opcode_in) == OP_TSTR) |=> done_out
		&& next_pc_out == $past(pc_in) + 32'h0000_0002 && !wb_out.we)
		else $error("and-test timing or pc wrong");
endmodule : insn_exec
`default_nettype wire

// [verif/mem_model.sv]
// memory model on the far side of the execution unit; the bench drives the cache lookup inputs
// assumes byte requests held until ack, one ack per request
`default_nettype none
module mem_model (
	input wire logic clk_in, // core clock
	input wire logic [1:0] delay_in, // cycles of wait before ack
	input wire insn_exec_pkg::mem_req_t req_in, // request
	output logic ack_out, // one-cycle answer
	output logic [7:0] rdata_out // read byte, valid with ack
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [16]; // byte store, index is low address bits
	logic [1:0] wait_q; // cycles left before ack
	initial begin
		for (int i = 0; i < 16; i++)
			mem[i] = 8'((i % 2) * 29);
	end
	// answer after the wait, never twice for one request; unknown request before reset counts as idle
	always @(posedge clk_in) begin
		if (ack_out !== 1'b0 || req_in.req !== 1'b1) begin
			ack_out <= 1'b0;
			rdata_out <= ~rdata_out; // released line keeps no value
			wait_q <= delay_in;
		end else if (wait_q != 2'h0) begin
			wait_q <= wait_q - 2'h1;
			rdata_out <= ~rdata_out;
		end else begin
			ack_out <= 1'b1;
			if (!req_in.wr)
				rdata_out <= mem[req_in.addr[3:0]];
			else if (!req_in.purge)
				mem[req_in.addr[3:0]] <= req_in.wdata;
		end
	end
endmodule // mem_model
`default_nettype wire

// [verif/insn_exec_tb.sv]
// self-checking bench: random instructions against a behavioural model
// assumes mem_model on the memory port and a 100 MHz core clock
`default_nettype none
module insn_exec_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in, srst_in, start_in, ack, hit, dirty, cach, acc_st, lwb, linv, busy, done, t, bsy;
	logic [15:0] opc;
	logic [31:0] pc, rm, rn, r0, global_base, vector_base, npc, sw, saved_status, saved_pc, software_exc_code, evt, wbd, ed, st, imm, ea;
	logic [7:0] rdata, b;
	logic [3:0] wbi;
	logic [1:0] dly;
	insn_exec_pkg::mem_req_t mreq;
	insn_exec_pkg::reg_wb_t wb;
	insn_exec_pkg::mem_req_t got_q[$], exp_q[$]; // seen and expected requests
	logic acc_q[$]; // store-check flag per request
	logic [7:0] ref_mem [16]; // mirror of the model's bytes
	logic [15:0] base_t [11], fld_t [11]; // opcode table and free bits
	int fails, num_checks, seed, nwb, nlwb, ninv, n, k, j, ewb, elwb, einv, lat;
	insn_exec u_insn_exec (.clk_in(clk_in), .srst_in(srst_in), .start_in(start_in), .opcode_in(opc),
		.pc_in(pc), .rm_in(rm), .rn_in(rn), .r0_in(r0), .global_base_in(global_base), .vector_base_in(vector_base),
		.mem_ack_in(ack), .mem_rdata_in(rdata), .cache_hit_in(hit), .dirty_mark_in(dirty),
		.cacheable_in(cach), .busy_out(busy), .done_out(done), .mem_out(mreq), .access_store_out(acc_st),
		.line_wb_out(lwb), .line_inval_out(linv), .wb_out(wb), .next_pc_out(npc), .status_word_out(sw),
		.saved_status_out(saved_status), .saved_pc_out(saved_pc), .software_exc_code_out(software_exc_code),
		.exception_event_code_out(evt));
	mem_model u_mem_model (.clk_in(clk_in), .delay_in(dly), .req_in(mreq), .ack_out(ack), .rdata_out(rdata));
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	// record writebacks, line strobes and answered requests
	always @(posedge clk_in) begin
		if (wb.we === 1'b1) begin
			nwb++;
			wbi = wb.idx;
			wbd = wb.data;
		end
		nlwb += int'(lwb === 1'b1);
		ninv += int'(linv === 1'b1);
		if (ack && mreq.req === 1'b1) begin
			got_q.push_back(mreq);
			acc_q.push_back(acc_st);
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	// request fields; lock and store check only for test-and-set
	task automatic chk_req(input insn_exec_pkg::mem_req_t e, input insn_exec_pkg::mem_req_t g, input logic ts,
		input logic acc);
		num_checks++;
		if (g.wr !== e.wr || g.purge !== e.purge || g.addr !== e.addr || (e.wr && !e.purge && g.wdata !== e.wdata)
			|| (ts && (g.lock !== 1'b1 || (!e.purge && acc !== 1'b1))) || (!ts && acc !== 1'b0)) begin
			fails++;
			$display("mismatch request expected %h seen %h", e, g);
		end
	endtask
	function automatic insn_exec_pkg::mem_req_t rq(input logic w, input logic p, input logic [31:0] a,
		input logic [7:0] d);
		rq = {1'b1, w, 1'b1, p, a, d};
	endfunction
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// issue one instruction with random operands, bounded wait for done
	task automatic run(input logic [15:0] o, input logic [2:0] c);
		@(posedge clk_in);
		nwb = 0;
		nlwb = 0;
		ninv = 0;
		got_q.delete();
		acc_q.delete();
		opc <= o;
		{pc, rm, rn} <= {$random(seed), $random(seed), $random(seed)};
		{r0, global_base, vector_base} <= {$random(seed), $random(seed), $random(seed)};
		{hit, dirty, cach} <= c; // cache state walks all combinations over the test-and-set runs
		dly <= 2'($random(seed));
		start_in <= 1'b1;
		@(posedge clk_in);
		start_in <= 1'b0;
		#1;
		bsy = busy;
		for (n = 1; n <= 60; n++) begin
			@(posedge clk_in);
			if (done === 1'b1)
				break;
		end
		#1;
		if (n > 60) begin
			fails++;
			$display("mismatch done expected 1 seen 0");
			results();
		end
	endtask
	initial begin
		seed = 92937;
		fails = 0;
		num_checks = 0;
		srst_in = 1'b1;
		start_in = 1'b0;
		opc = 16'h0000;
		{pc, rm, rn, r0, global_base, vector_base} = '0;
		{hit, dirty, cach, dly} = '0;
		base_t = '{insn_exec_pkg::OPC_SWAPB, insn_exec_pkg::OPC_SWAPW, insn_exec_pkg::OPC_TSTR,
			insn_exec_pkg::OPC_TSTI, insn_exec_pkg::OPC_TSTM, insn_exec_pkg::OPC_XORR, insn_exec_pkg::OPC_XORI,
			insn_exec_pkg::OPC_XORM, insn_exec_pkg::OPC_TAS, insn_exec_pkg::OPC_TRAP, 16'hFFFF};
		fld_t = '{16'h0FF0, 16'h0FF0, 16'h0FF0, 16'h00FF, 16'h00FF, 16'h0FF0, 16'h00FF, 16'h00FF, 16'h0F00,
			16'h00FF, 16'h0000};
		for (int i = 0; i < 16; i++)
			ref_mem[i] = 8'((i % 2) * 29);
		st = insn_exec_pkg::SR_RESET;
		repeat (2) @(posedge clk_in);
		srst_in <= 1'b0;
		#1;
		chk("status reset", st, sw);
		for (k = 0; k < 110; k++) begin
			j = k % 11;
			run(base_t[j] | (16'($random(seed)) & fld_t[j]), 3'(k / 11));
			imm = {24'h00_0000, opc[7:0]};
			ea = global_base + r0;
			b = ref_mem[ea[3:0]];
			exp_q.delete();
			ewb = int'(j inside {0, 1, 5, 6});
			{elwb, einv, lat} = {32'd0, 32'd0, 32'd1};
			ed = 32'h0000_0000;
			t = st[0];
			case (j)
				0: ed = {rm[31:16], rm[7:0], rm[15:8]};
				1: ed = {rm[15:0], rm[31:16]};
				2: t = (rn & rm) == 32'h0000_0000;
				3: t = (r0 & imm) == 32'h0000_0000;
				4: begin
					t = (b & imm[7:0]) == 8'h00;
					exp_q.push_back(rq(1'b0, 1'b0, ea, 8'h00));
					lat = 0;
				end
				5: ed = rn ^ rm;
				6: ed = r0 ^ imm;
				7: begin
					exp_q.push_back(rq(1'b0, 1'b0, ea, 8'h00));
					exp_q.push_back(rq(1'b1, 1'b0, ea, b ^ imm[7:0]));
					ref_mem[ea[3:0]] = b ^ imm[7:0];
					lat = 0;
				end
				8: begin
					b = ref_mem[rn[3:0]];
					einv = int'(hit && cach);
					elwb = int'(hit && cach && dirty);
					if (elwb != 0)
						exp_q.push_back(rq(1'b1, 1'b1, rn, 8'h00));
					exp_q.push_back(rq(1'b0, 1'b0, rn, 8'h00));
					exp_q.push_back(rq(1'b1, 1'b0, rn, b | 8'h80));
					ref_mem[rn[3:0]] = b | 8'h80;
					t = b == 8'h00;
					lat = 0;
				end
				9: begin
					chk("trap code", imm << 2, software_exc_code);
					chk("saved pc", pc + 32'h0000_0002, saved_pc);
					chk("saved status", st, saved_status);
					chk("event code", 32'h0000_0160, {20'h0_0000, evt[11:0]});
					st[30:28] = 3'h7;
					lat = 3;
				end
				default: ;
			endcase
			st[0] = t;
			if (lat != 0)
				chk("latency", lat, n);
			chk("next pc", j == 9 ? vector_base + 32'h0000_0100 : pc + 32'h0000_0002, npc);
			chk("status", st, sw);
			chk("busy", int'(j inside {4, 7, 8, 9}) * 2, 32'({bsy, busy}));
			chk("wb count", ewb, nwb);
			if (ewb != 0) begin
				chk("wb index", j == 6 ? 0 : opc[11:8], wbi);
				chk("wb data", ed, wbd);
			end
			chk("line wb", elwb, nlwb);
			chk("line inval", einv, ninv);
			chk("requests", exp_q.size(), got_q.size());
			foreach (exp_q[i])
				if (i < got_q.size())
					chk_req(exp_q[i], got_q[i], j == 8, acc_q[i]);
			$display("test %0d opcode %h done", k, opc);
		end
		results();
	end
endmodule // insn_exec_tb
`default_nettype wire
